// ==== design/pbs_port.sv ====
// Purpose: Device-side logic of a pipelined burst SRAM port
// Assumes: All inputs synchronous to clk except out_gate_n and sleep
// Notes:   Data pin is split into input, output and output enable
//
// Summary of operation
// - Register every input except out_gate_n, and data output
// - Read starts on strobe, selects, no write
// - Ignore processor strobe while first select high
// - Read data appears two cycles after the strobe
// - First cycle after deselect stays undriven
// - Deselect turns drivers off at once
// - Processor-strobe write completes on second edge
// - Byte gate writes only selected lanes
// - Global write writes all four lanes
// - Drivers off whenever write detected
// - Controller-strobe write completes in one cycle
// - Burst counter clears to zero; base loads the address
// - Burst step low advances the counter
// - Interleaved order is start xor count
// - Linear order counts up modulo four
// - Order chosen by sampled order select
// - Order select low linear, high interleaved
// - Sleep takes two cycles, keeps data
// - Access pending at sleep is dropped
`timescale 1ns/1ps
module pbs_port (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [pbs_pkg::ADDR_W-1:0]    addr,
	input  wire logic                          proc_addr_strobe_n,
	input  wire logic                          ctrl_addr_strobe_n,
	input  wire logic                          burst_step_n,
	input  wire logic                          byte_write_gate_n,
	input  wire logic [pbs_pkg::LANES-1:0]     byte_lane_sel_n,
	input  wire logic                          global_write_n,
	input  wire logic                          chip_select_first_n,
	input  wire logic                          chip_select_second,
	input  wire logic                          chip_select_third_n,
	input  wire logic                          out_gate_n,
	input  wire logic                          burst_order_sel,
	input  wire logic                          sleep_request,
	input  wire logic [pbs_pkg::DATA_W-1:0]    dq_in,
	output logic      [pbs_pkg::DATA_W-1:0]    dq_out,
	output logic      [pbs_pkg::DATA_W-1:0]    dq_oe,
	output logic                               sleep_active
);
	import pbs_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [BURST_W-1:0] burst_next(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt,
		input logic               interleave
	);
		logic [BURST_W-1:0] r;
		r = interleave ? (start ^ cnt) : BURST_W'(start + cnt);
		return r;
	endfunction

	function automatic logic [LANES-1:0] lane_mask(
		input logic             gw_n,
		input logic             bwe_n,
		input logic [LANES-1:0] sel_n
	);
		logic [LANES-1:0] m;
		if (!gw_n) begin
			m = LANES_ALL;
		end else if (!bwe_n) begin
			m = ~sel_n;
		end else begin
			m = LANES_NONE;
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Input registers
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] addr_q;
	logic              proc_addr_strobe_n_n_q, ctrl_addr_strobe_n_n_q, step_n_q;
	logic              bwe_n_q, gw_n_q;
	logic [LANES-1:0]  sel_n_q;
	logic              ce1_n_q, ce2_q, ce3_n_q;
	logic [DATA_W-1:0] din_q;
	logic              order_q;
	logic              zz_s1_q, zz_s2_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_q <= ADDR_ZERO;
			din_q  <= DATA_ZERO;
		end else begin
			addr_q <= addr;
			din_q  <= dq_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			proc_addr_strobe_n_n_q <= 1'b1;
			ctrl_addr_strobe_n_n_q <= 1'b1;
			step_n_q <= 1'b1;
		end else begin
			proc_addr_strobe_n_n_q <= proc_addr_strobe_n;
			ctrl_addr_strobe_n_n_q <= ctrl_addr_strobe_n;
			step_n_q <= burst_step_n;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bwe_n_q <= 1'b1;
			gw_n_q  <= 1'b1;
			sel_n_q <= LANES_ALL;
		end else begin
			bwe_n_q <= byte_write_gate_n;
			gw_n_q  <= global_write_n;
			sel_n_q <= byte_lane_sel_n;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ce1_n_q <= 1'b1;
			ce2_q   <= 1'b0;
			ce3_n_q <= 1'b1;
		end else begin
			ce1_n_q <= chip_select_first_n;
			ce2_q   <= chip_select_second;
			ce3_n_q <= chip_select_third_n;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			order_q <= 1'b1;
		end else begin
			order_q <= burst_order_sel;
		end
	end

	// ------------------------------------------------------------
	// Sleep synchroniser
	// ------------------------------------------------------------

	// Asynchronous sleep input is brought in through two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zz_s1_q <= 1'b0;
			zz_s2_q <= 1'b0;
		end else begin
			zz_s1_q <= sleep_request;
			zz_s2_q <= zz_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Cycle decode on registered inputs
	// ------------------------------------------------------------
	logic selected, proc_addr_strobe_n_hit, ctrl_addr_strobe_n_hit, start, desel, wr_req, cont;
	logic [LANES-1:0] mask_now;
	pbs_state_e state_q;
	logic sleeping;

	assign sleeping = (state_q == PBS_SLEEP);
	assign selected = !ce1_n_q && ce2_q && !ce3_n_q;
	// Processor strobe masked by first select
	assign proc_addr_strobe_n_hit = !proc_addr_strobe_n_n_q && !ce1_n_q;
	assign ctrl_addr_strobe_n_hit = !ctrl_addr_strobe_n_n_q && proc_addr_strobe_n_n_q;
	assign start    = !sleeping && selected && (proc_addr_strobe_n_hit || !ctrl_addr_strobe_n_n_q);
	// Deselect by selects with a strobe
	assign desel    = !sleeping && !selected && (proc_addr_strobe_n_hit || !ctrl_addr_strobe_n_n_q);
	assign mask_now = lane_mask(gw_n_q, bwe_n_q, sel_n_q);
	assign wr_req   = (mask_now != LANES_NONE);
	assign cont     = !sleeping && ctrl_addr_strobe_n_n_q && (proc_addr_strobe_n_n_q || ce1_n_q);

	// ------------------------------------------------------------
	// Access state
	// ------------------------------------------------------------
	logic [ADDR_W-1:0]  base_q;
	logic [BURST_W-1:0] cnt_q;
	logic [1:0]         zz_cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= PBS_IDLE;
		end else begin
			case (state_q)
				PBS_SLEEP: begin
					if (!zz_s2_q && zz_cnt_q == SLEEP_CNT_ZERO) begin
						state_q <= PBS_IDLE;
					end
				end
				default: begin
					if (zz_s2_q && zz_cnt_q == SLEEP_CNT_MAX) begin
						state_q <= PBS_SLEEP;
					end else if (desel) begin
						state_q <= PBS_IDLE;
					end else if (start) begin
						if (!proc_addr_strobe_n_hit && ctrl_addr_strobe_n_hit && wr_req) begin
							state_q <= PBS_WRITE;
						end else begin
							state_q <= PBS_READ;
						end
					end else if (cont && state_q != PBS_IDLE) begin
						state_q <= wr_req ? PBS_WRITE : PBS_READ;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sleep and burst counters
	// ------------------------------------------------------------
	// Sleep entry and exit counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zz_cnt_q <= SLEEP_CNT_ZERO;
		end else if (zz_s2_q && zz_cnt_q != SLEEP_CNT_MAX) begin
			zz_cnt_q <= 2'(zz_cnt_q + 2'h1);
		end else if (!zz_s2_q && zz_cnt_q != SLEEP_CNT_ZERO) begin
			zz_cnt_q <= 2'(zz_cnt_q - 2'h1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_q <= ADDR_ZERO;
			cnt_q  <= BURST_ZERO;
		end else if (start && !desel) begin
			base_q <= addr_q;
			cnt_q  <= BURST_ZERO;
		end else if (cont && !step_n_q && state_q != PBS_IDLE) begin
			cnt_q  <= 2'(cnt_q + BURST_ONE);
		end
	end

	// ------------------------------------------------------------
	// Array access
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] mem_addr;
	logic [LANES-1:0]  mem_we;
	logic [DATA_W-1:0] mem_rdata;
	logic [BURST_W-1:0] low_bits;
	logic              in_burst;

	assign low_bits = burst_next(base_q[BURST_W-1:0],
		cont && !step_n_q ? 2'(cnt_q + BURST_ONE) : cnt_q, order_q);
	assign in_burst = cont && state_q != PBS_IDLE;
	assign mem_addr = (start && !desel) ? addr_q :
		{base_q[ADDR_W-1:BURST_W], low_bits};

	assign mem_we = (!sleeping && ((start && !desel && !proc_addr_strobe_n_hit && ctrl_addr_strobe_n_hit)
		|| in_burst)) ? mask_now : LANES_NONE;

	pbs_mem u_mem (
		.clk     (clk),
		.addr    (mem_addr),
		.lane_we (mem_we),
		.wdata   (din_q),
		.rdata   (mem_rdata)
	);

	// ------------------------------------------------------------
	// Output registers and driver control
	// ------------------------------------------------------------
	logic rd_cycle_q, first_q, wr_cycle_q;

	// Read cycle marker
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_cycle_q <= 1'b0;
		end else begin
			rd_cycle_q <= (start || in_burst) && !desel && !sleeping
				&& mem_we == LANES_NONE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_q <= 1'b0;
		end else begin
			first_q <= start && state_q == PBS_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_cycle_q <= 1'b0;
		end else begin
			wr_cycle_q <= mem_we != LANES_NONE;
		end
	end

	// One cycle pipeline to the pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_out <= DATA_ZERO;
		end else begin
			dq_out <= mem_rdata;
		end
	end

	// Gate sampled each edge; master lifts it before writing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_oe <= DATA_ZERO;
		end else if (rd_cycle_q && !first_q && !wr_cycle_q && !out_gate_n
			&& !desel && !sleeping
			&& mem_we == LANES_NONE) begin
			dq_oe <= ~DATA_ZERO;
		end else begin
			dq_oe <= DATA_ZERO;
		end
	end

	// ------------------------------------------------------------
	// Sleep status
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_active <= 1'b0;
		end else begin
			sleep_active <= sleeping;
		end
	end
endmodule // pbs_port

// ==== design/pbs_pkg.sv ====
// Purpose: Shared constants for the pipelined burst SRAM port
// Assumes: 25 MHz clock, 128K x 32 array
// Notes:   Sleep timing is counted in clock cycles
package pbs_pkg;
	localparam int ADDR_W       = 17;
	localparam int DATA_W       = 32;
	localparam int LANES        = 4;
	localparam int LANE_W       = 8;
	localparam int BURST_W      = 2;
	localparam int DEPTH        = 131072;
	localparam int CLK_PERIOD_NS = 40;
	// Sleep entry and exit span two clock cycles
	localparam int SLEEP_CYCLES_CFG = 2;
	localparam int SLEEP_ENTRY_CYCLES = SLEEP_CYCLES_CFG;
	localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;
	localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;
	localparam logic [LANES-1:0] LANES_ALL = 4'hf;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0_0000;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

	typedef enum logic [1:0] {
		PBS_IDLE  = 2'b00,
		PBS_READ  = 2'b01,
		PBS_WRITE = 2'b10,
		PBS_SLEEP = 2'b11
	} pbs_state_e;
endpackage

// ==== design/pbs_mem.sv ====
// Purpose: 128K x 32 storage array with byte-lane writes
// Assumes: Single clock, registered read data
// Notes:   Stored data survives sleep; there is no reset of contents
`timescale 1ns/1ps
module pbs_mem (
	input  wire logic                          clk,
	input  wire logic [pbs_pkg::ADDR_W-1:0]    addr,
	input  wire logic [pbs_pkg::LANES-1:0]     lane_we,
	input  wire logic [pbs_pkg::DATA_W-1:0]    wdata,
	output logic      [pbs_pkg::DATA_W-1:0]    rdata
);
	import pbs_pkg::*;

	logic [DATA_W-1:0] mem_q [DEPTH];

	// ------------------------------------------------------------
	// Write and read ports
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (lane_we[i]) begin
				mem_q[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
			end
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem_q[addr];
	end
endmodule // pbs_mem

// ==== dv/pbs_port_assertions.sv ====
// Purpose: Port checks for the burst SRAM port
// Assumes: Single clock, rst active high
// Notes:   Sees the top module ports only
`timescale 1ns/1ps
module pbs_port_checker (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic                       proc_addr_strobe_n,
	input wire logic                       ctrl_addr_strobe_n,
	input wire logic                       global_write_n,
	input wire logic                       chip_select_first_n,
	input wire logic                       chip_select_second,
	input wire logic                       chip_select_third_n,
	input wire logic                       out_gate_n,
	input wire logic                       sleep_request,
	input wire logic [pbs_pkg::DATA_W-1:0] dq_oe,
	input wire logic                       sleep_active
);
	import pbs_pkg::*;
	wire sel = !chip_select_first_n && chip_select_second
		&& !chip_select_third_n;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Output drivers
	// ----------------------------------------------------------------
	a_write_no_drive: assert property (
		!ctrl_addr_strobe_n && proc_addr_strobe_n && sel && !global_write_n
		|-> ##2 dq_oe == '0) else $error("driving during a write");
	a_desel_off: assert property (
		!ctrl_addr_strobe_n && chip_select_first_n |-> ##2 dq_oe == '0)
		else $error("driving after deselect");
	a_gate_off: assert property (out_gate_n |=> dq_oe == '0)
		else $error("driving with gate high");
	a_oe_whole: assert property (dq_oe == '0 || dq_oe == '1)
		else $error("partial output enable");
	// ----------------------------------------------------------------
	// Sleep
	// ----------------------------------------------------------------
	a_sleep_quiet: assert property (sleep_active |-> dq_oe == '0)
		else $error("driving in sleep");
	a_sleep_enter: assert property (
		$rose(sleep_request) |-> ##[1:8] sleep_active)
		else $error("sleep not entered");
	a_sleep_leave: assert property (
		$fell(sleep_request) |-> ##[1:8] !sleep_active)
		else $error("sleep not left");
	a_sleep_hold: assert property (
		sleep_active && sleep_request |=> sleep_active)
		else $error("sleep dropped early");
endmodule // pbs_port_checker

bind pbs_port pbs_port_checker u_chk (.clk, .rst, .proc_addr_strobe_n,
	.ctrl_addr_strobe_n, .global_write_n, .chip_select_first_n,
	.chip_select_second, .chip_select_third_n, .out_gate_n,
	.sleep_request, .dq_oe, .sleep_active);

// ==== dv/pbs_master_model.sv ====
// Purpose: Bus master model facing the SRAM port
// Assumes: Tasks are called at the falling clock edge
// Notes:   Bench shows released data lines inverted
`timescale 1ns/1ps
module pbs_master_model (
	output logic [pbs_pkg::ADDR_W-1:0] addr,
	output logic                       proc_addr_strobe_n,
	output logic                       ctrl_addr_strobe_n,
	output logic                       burst_step_n,
	output logic                       byte_write_gate_n,
	output logic [pbs_pkg::LANES-1:0]  byte_lane_sel_n,
	output logic                       global_write_n,
	output logic                       chip_select_first_n,
	output logic                       chip_select_second,
	output logic                       chip_select_third_n,
	output logic                       out_gate_n,
	output logic                       burst_order_sel,
	output logic                       sleep_request,
	output logic [pbs_pkg::DATA_W-1:0] wdata,
	output logic                       wdata_en
);
	import pbs_pkg::*;
	task automatic acc(input logic c1, ps, cs, st, gw, bw,
		input logic [3:0] ln, input logic [16:0] a, input logic [31:0] d);
		logic wr;
		wr = !gw || (!bw && ln != 4'hf);
		{chip_select_first_n, chip_select_second} = {c1, 1'b1};
		chip_select_third_n = 1'b0;
		{proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = {ps, cs, st};
		{global_write_n, byte_write_gate_n, byte_lane_sel_n} = {gw, bw, ln};
		addr = a;
		out_gate_n = wr;
		wdata_en = wr && ps;
		if (wr && ps)
			wdata = d;
	endtask
	task automatic idle();
		acc(1, 1, 1, 1, 1, 1, 4'hf, ADDR_ZERO, DATA_ZERO);
	endtask
	task automatic strap(input logic o, z);
		{burst_order_sel, sleep_request} = {o, z};
		wdata = DATA_ZERO;
	endtask
endmodule // pbs_master_model

// ==== dv/pbs_port_tb_top.sv ====
// Purpose: Self-checking bench for the burst SRAM port
// Assumes: Inputs change at the falling edge
// Notes:   Read data checked two edges after the start edge
`timescale 1ns/1ps
module pbs_port_tb_top;
	import pbs_pkg::*;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic              proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
	logic              byte_write_gate_n, global_write_n, out_gate_n;
	logic [LANES-1:0]  byte_lane_sel_n;
	logic              chip_select_first_n, chip_select_second;
	logic              chip_select_third_n, burst_order_sel, sleep_request;
	logic [DATA_W-1:0] wdata, dq_in, dq_out, dq_oe;
	logic              wdata_en, sleep_active;
	int                miscompares = 0, total_checks = 0, cycles = 0;
	assign dq_in = wdata_en ? wdata : (dq_out & dq_oe) | (~wdata & ~dq_oe);
	pbs_master_model m (.addr, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
		.burst_step_n, .byte_write_gate_n, .byte_lane_sel_n, .global_write_n,
		.chip_select_first_n, .chip_select_second, .chip_select_third_n,
		.out_gate_n, .burst_order_sel, .sleep_request, .wdata, .wdata_en);
	pbs_port uut (.clk, .rst, .addr, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
		.burst_step_n, .byte_write_gate_n, .byte_lane_sel_n, .global_write_n,
		.chip_select_first_n, .chip_select_second, .chip_select_third_n,
		.out_gate_n, .burst_order_sel, .sleep_request, .dq_in, .dq_out,
		.dq_oe, .sleep_active);
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [16:0] a, input logic [31:0] d,
		input logic gw, bw, input logic [3:0] ln);
		@(negedge clk) m.acc(0, 1, 0, 1, gw, bw, ln, a, d);
		@(negedge clk) m.idle();
	endtask
	task automatic rd(input logic [16:0] a, input logic [31:0] e);
		@(negedge clk) m.acc(0, 1, 0, 1, 1, 1, 4'hf, a, DATA_ZERO);
		@(negedge clk) m.idle();
		repeat (2) @(negedge clk);
		chk(dq_out, e);
	endtask
	task automatic t_writes();
		wr(17'h10, 32'h11223344, 0, 1, 4'hf);
		rd(17'h10, 32'h11223344);
		wr(17'h10, 32'haabbccdd, 1, 0, 4'ha);
		rd(17'h10, 32'h11bb33dd);
		@(negedge clk) m.acc(0, 0, 1, 1, 0, 1, 4'hf, 17'h20, DATA_ZERO);
		@(negedge clk) m.acc(0, 1, 1, 1, 0, 1, 4'hf, 17'h20, 32'h5a5a0f0f);
		@(negedge clk) m.idle();
		rd(17'h20, 32'h5a5a0f0f);
		@(negedge clk) m.acc(1, 1, 0, 1, 1, 1, 4'hf, 17'h20, DATA_ZERO);
		@(negedge clk) m.acc(1, 0, 1, 1, 1, 1, 4'hf, 17'h20, DATA_ZERO);
		@(negedge clk) m.acc(1, 1, 1, 1, 0, 1, 4'hf, 17'h20, 32'hdead0000);
		@(negedge clk) m.idle();
		rd(17'h20, 32'h5a5a0f0f);
	endtask
	task automatic t_burst(input logic o, input logic [1:0] s);
		logic [1:0] n [5];
		logic [1:0] lo;
		n = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
		m.strap(o, 1'b0);
		for (int i = 0; i < 9; i++) begin
			@(negedge clk);
			if (i >= 4) begin
				lo = o ? s ^ n[i-4] : s + n[i-4];
				chk(dq_out, 32'hc0de0000 | lo);
			end
			if (i == 4)
				chk(dq_oe, DATA_ZERO);
			if (i == 5)
				chk(dq_oe, 32'hffffffff);
			case (i)
				0: m.acc(1, 1, 0, 1, 1, 1, 4'hf, ADDR_ZERO, DATA_ZERO);
				1: m.acc(0, 1, 0, 1, 1, 1, 4'hf, {15'h10, s}, DATA_ZERO);
				2, 4, 5: m.acc(0, 1, 1, 0, 1, 1, 4'hf, ADDR_ZERO, DATA_ZERO);
				default: m.idle();
			endcase
		end
	endtask
	task automatic t_sleep();
		int n;
		@(negedge clk) m.acc(1, 1, 0, 1, 1, 1, 4'hf, ADDR_ZERO, DATA_ZERO);
		@(negedge clk) m.idle();
		m.strap(1'b1, 1'b1);
		n = 0;
		while (sleep_active !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, sleep_active}, 32'h1);
		m.strap(1'b1, 1'b0);
		n = 0;
		while (sleep_active !== 1'b0 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, sleep_active}, 32'h0);
		repeat (2) @(negedge clk);
		rd(17'h42, 32'hc0de0002);
	endtask
	task automatic end_of_test();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		m.idle();
		m.strap(1'b1, 1'b0);
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		t_writes();
		for (int j = 0; j < 4; j++)
			wr(17'h40 + j, 32'hc0de0000 + j, 0, 1, 4'hf);
		t_burst(1'b1, 2'h1);
		t_burst(1'b0, 2'h2);
		t_sleep();
		end_of_test();
	end
endmodule // pbs_port_tb_top
